//--- hw/cca_defines.svh
// constants for the complement and compare execution block
// assumes inclusion by bare name from package and test files
`ifndef CCA_DEFINES_SVH
`define CCA_DEFINES_SVH

// opcodes of the complement instruction
`define CCA_OPC_COM_REG      8'h60
`define CCA_OPC_COM_IND      8'h61

// instruction length in bytes and execution cycles
`define CCA_COM_BYTES        2
`define CCA_COM_CYCLES       4
`define CCA_CMP_CYCLES       6

// software register offsets (byte addresses)
`define CCA_OFS_CTRL         4'h0
`define CCA_OFS_STATUS       4'h4
`define CCA_OFS_DONE_CNT     4'h8
`define CCA_OFS_REFUSE_CNT   4'hc

// control register fields and reset value
`define CCA_CTRL_EN_BIT      0
`define CCA_CTRL_RESET       1'b1

// status register field positions
`define CCA_ST_RESULT_LSB    0
`define CCA_ST_FLAGS_LSB     8
`define CCA_ST_REFUSED_BIT   16
`define CCA_ST_BUSY_BIT      17

// byte sign bit
`define CCA_SIGN_BIT         7

`endif

//--- hw/cca_pkg.sv
// types shared by the complement and compare execution block
// assumes cca_defines.svh on the include path
`include "cca_defines.svh"

package cca_pkg;

    // source addressing for the compare operation
    typedef enum logic [2:0] {
        CCA_SRC_WREG     = 3'h0,
        CCA_SRC_WREG_IND = 3'h1,
        CCA_SRC_GREG     = 3'h2,
        CCA_SRC_GREG_IND = 3'h3,
        CCA_SRC_IMM      = 3'h4
    } cca_src_mode_t;

    // condition flags
    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
    } cca_flags_t;

    // request from the decoder
    typedef struct packed {
        logic          cmp;
        logic [7:0]    opcode;
        cca_src_mode_t src_mode;
        logic [7:0]    dst;
        logic [7:0]    src;
        cca_flags_t    flags;
    } cca_req_t;

    // answer to register file and flags register
    typedef struct packed {
        logic       valid;
        logic       write_en;
        logic       dst_indirect;
        logic       refused;
        logic [7:0] result;
        cca_flags_t flags;
    } cca_rsp_t;

    // software register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cca_bus_t;

endpackage

//--- hw/cca_alu.sv
// complement and compare execution block of the core
// assumes decoder supplies fetched operands, same clock, sync reset
//
// Notes on behaviour
// - complement writes bitwise inverse of destination
// - complement zero on zero result, sign bit 7
// - complement clears overflow, keeps carry, decimal, half
// - complement two bytes, 4 cycles, opcodes 60/61
// - compare derives flags only, writes nothing back
// - compare carry set on borrow
// - compare zero set when difference zero
// - compare sign set when difference negative
// - compare overflow on signed overflow, keeps decimal, half
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps

module cca_alu (
    input  wire  logic              core_clk,
    input  wire  logic              rst,
    input  wire  logic              req_valid,
    input  wire  cca_pkg::cca_req_t req,
    output logic                    req_ready,
    output cca_pkg::cca_rsp_t       rsp,
    input  wire  cca_pkg::cca_bus_t bus,
    output logic [31:0]             bus_rdata
);
    import cca_pkg::*;

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CCA_ST_IDLE = 2'b00,
        CCA_ST_EXEC = 2'b01
    } cca_state_t;

    localparam logic [3:0] COM_WAIT = 4'(`CCA_COM_CYCLES - 2);
    localparam logic [3:0] CMP_WAIT = 4'(`CCA_CMP_CYCLES - 2);

    cca_state_t  state_reg;
    cca_state_t  state_next;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    cca_req_t    op_reg;
    cca_req_t    op_next;
    logic        ready_reg;
    logic        ready_next;
    cca_rsp_t    rsp_reg;
    cca_rsp_t    rsp_next;

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic        en_reg;
    logic        en_next;
    logic [7:0]  last_result_reg;
    logic [7:0]  last_result_next;
    cca_flags_t  last_flags_reg;
    cca_flags_t  last_flags_next;
    logic        last_refused_reg;
    logic        last_refused_next;
    logic [15:0] done_cnt_reg;
    logic [15:0] done_cnt_next;
    logic [15:0] refuse_cnt_reg;
    logic [15:0] refuse_cnt_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // ------------------------------------------------------------
    // request checks
    // ------------------------------------------------------------
    logic take;
    logic com_opc_ok;
    logic src_ok;
    logic req_ok;

    always_comb begin
        take       = req_valid & ready_reg;
        com_opc_ok = (req.opcode == `CCA_OPC_COM_REG) ||
                     (req.opcode == `CCA_OPC_COM_IND);
        // five source modes accepted, others refused
        case (req.src_mode)
            CCA_SRC_WREG,
            CCA_SRC_WREG_IND,
            CCA_SRC_GREG,
            CCA_SRC_GREG_IND,
            CCA_SRC_IMM: src_ok = 1'b1;
            default:     src_ok = 1'b0;
        endcase
        req_ok = en_reg & (req.cmp ? src_ok : com_opc_ok);
    end

    // ------------------------------------------------------------
    // complement of the held operation
    // ------------------------------------------------------------
    logic [7:0] com_val;
    cca_flags_t com_flags;
    logic [8:0] diff;
    cca_flags_t cmp_flags;
    genvar      gi;

    // bitwise inversion, one cell per bit
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_inv
            assign com_val[gi] = ~op_reg.dst[gi];
        end
    endgenerate

    always_comb begin
        com_flags   = op_reg.flags;
        com_flags.z = (com_val == 8'h00);
        com_flags.s = com_val[`CCA_SIGN_BIT];
        com_flags.v = 1'b0;
    end

    // ------------------------------------------------------------
    // compare of the held operation
    // ------------------------------------------------------------
    always_comb begin
        diff        = {1'b0, op_reg.dst} - {1'b0, op_reg.src};
        cmp_flags   = op_reg.flags;
        cmp_flags.c = diff[8];
        cmp_flags.z = (diff[7:0] == 8'h00);
        cmp_flags.s = diff[`CCA_SIGN_BIT];
        cmp_flags.v = (op_reg.dst[`CCA_SIGN_BIT] ^ op_reg.src[`CCA_SIGN_BIT]) &
                      (op_reg.dst[`CCA_SIGN_BIT] ^ diff[`CCA_SIGN_BIT]);
    end

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        op_next    = op_reg;
        ready_next = ready_reg;
        rsp_next   = '0;
        case (state_reg)
            CCA_ST_IDLE: begin
                if (take && req_ok) begin
                    op_next    = req;
                    ready_next = 1'b0;
                    state_next = CCA_ST_EXEC;
                    cnt_next   = req.cmp ? CMP_WAIT : COM_WAIT;
                end else if (take) begin
                    // refused request answered at once, nothing written
                    rsp_next.valid   = 1'b1;
                    rsp_next.refused = 1'b1;
                    rsp_next.result  = req.dst;
                    rsp_next.flags   = req.flags;
                end
            end
            CCA_ST_EXEC: begin
                if (cnt_reg == 4'h0) begin
                    state_next     = CCA_ST_IDLE;
                    ready_next     = 1'b1;
                    rsp_next.valid = 1'b1;
                    if (op_reg.cmp) begin
                        rsp_next.write_en = 1'b0;
                        rsp_next.result   = diff[7:0];
                        rsp_next.flags    = cmp_flags;
                    end else begin
                        rsp_next.write_en     = 1'b1;
                        rsp_next.dst_indirect = (op_reg.opcode == `CCA_OPC_COM_IND);
                        rsp_next.result       = com_val;
                        rsp_next.flags        = com_flags;
                    end
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default: begin
                state_next = CCA_ST_IDLE;
                ready_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= CCA_ST_IDLE;
            cnt_reg   <= 4'h0;
            op_reg    <= '0;
            ready_reg <= 1'b1;
            rsp_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            op_reg    <= op_next;
            ready_reg <= ready_next;
            rsp_reg   <= rsp_next;
        end
    end

    // ------------------------------------------------------------
    // control and last-answer registers
    // ------------------------------------------------------------
    always_comb begin
        en_next           = en_reg;
        last_result_next  = last_result_reg;
        last_flags_next   = last_flags_reg;
        last_refused_next = last_refused_reg;
        if (bus.wr && bus.addr == `CCA_OFS_CTRL) begin
            en_next = bus.wdata[`CCA_CTRL_EN_BIT];
        end
        // status follows every answer, refused ones too
        if (rsp_next.valid) begin
            last_result_next  = rsp_next.result;
            last_flags_next   = rsp_next.flags;
            last_refused_next = rsp_next.refused;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            en_reg           <= `CCA_CTRL_RESET;
            last_result_reg  <= 8'h00;
            last_flags_reg   <= '0;
            last_refused_reg <= 1'b0;
        end else begin
            en_reg           <= en_next;
            last_result_reg  <= last_result_next;
            last_flags_reg   <= last_flags_next;
            last_refused_reg <= last_refused_next;
        end
    end

    // ------------------------------------------------------------
    // answer counters
    // ------------------------------------------------------------
    always_comb begin
        done_cnt_next   = done_cnt_reg;
        refuse_cnt_next = refuse_cnt_reg;
        // writes clear; a same-cycle event still counts
        if (bus.wr && bus.addr == `CCA_OFS_DONE_CNT) begin
            done_cnt_next = 16'h0000;
        end
        if (bus.wr && bus.addr == `CCA_OFS_REFUSE_CNT) begin
            refuse_cnt_next = 16'h0000;
        end
        if (rsp_next.valid && rsp_next.refused) begin
            refuse_cnt_next = refuse_cnt_next + 16'h0001;
        end
        if (rsp_next.valid && !rsp_next.refused) begin
            done_cnt_next = done_cnt_next + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            done_cnt_reg   <= 16'h0000;
            refuse_cnt_reg <= 16'h0000;
        end else begin
            done_cnt_reg   <= done_cnt_next;
            refuse_cnt_reg <= refuse_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // read data, standing one cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (bus.rd) begin
            case (bus.addr)
                `CCA_OFS_CTRL: begin
                    rdata_next[`CCA_CTRL_EN_BIT] = en_reg;
                end
                `CCA_OFS_STATUS: begin
                    rdata_next[`CCA_ST_RESULT_LSB +: 8] = last_result_reg;
                    rdata_next[`CCA_ST_FLAGS_LSB +: 6]  = last_flags_reg;
                    rdata_next[`CCA_ST_REFUSED_BIT]     = last_refused_reg;
                    rdata_next[`CCA_ST_BUSY_BIT]        = ~ready_reg;
                end
                `CCA_OFS_DONE_CNT: begin
                    rdata_next[15:0] = done_cnt_reg;
                end
                `CCA_OFS_REFUSE_CNT: begin
                    rdata_next[15:0] = refuse_cnt_reg;
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        req_ready = ready_reg;
        rsp       = rsp_reg;
        bus_rdata = rdata_reg;
    end

endmodule

//--- test/cca_alu_checker.sv
// checker for the complement and compare block
// assumes binding to cca_alu, one clock, sync reset
`timescale 1ns/10ps
`include "cca_defines.svh"
module cca_alu_checker (
    input logic              core_clk,
    input logic              rst,
    input logic              req_valid,
    input cca_pkg::cca_req_t req,
    input logic              req_ready,
    input cca_pkg::cca_rsp_t rsp,
    input cca_pkg::cca_bus_t bus,
    input logic [31:0]       bus_rdata
);
    import cca_pkg::*;
    logic       en_reg, en_next, tk, tc, bad;
    logic [2:0] cdh;
    logic [1:0] dh;
    always_comb begin
        en_next = en_reg;
        if (bus.wr && bus.addr == `CCA_OFS_CTRL)
            en_next = bus.wdata[`CCA_CTRL_EN_BIT];
    end
    always_ff @(posedge core_clk) begin
        en_reg <= rst ? `CCA_CTRL_RESET : en_next;
    end
    // opcode 60 or 61 only
    assign tk  = req_valid && req_ready && en_reg && !req.cmp && req.opcode[7:1] == 7'h30;
    assign tc  = req_valid && req_ready && en_reg && req.cmp && req.src_mode <= CCA_SRC_IMM;
    assign bad = req_valid && req_ready && req.cmp && req.src_mode > CCA_SRC_IMM;
    assign cdh = {req.flags.c, req.flags.d, req.flags.h};
    assign dh  = {req.flags.d, req.flags.h};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_com;
        ##1 !req_ready [*3] ##1 req_ready && rsp.valid && rsp.write_en && !rsp.refused;
    endsequence
    sequence s_cmp;
        ##1 !req_ready [*5] ##1 req_ready && rsp.valid && !rsp.write_en && !rsp.refused;
    endsequence
    property p_com_lat; tk |-> s_com; endproperty
    property p_com_inv; tk |-> ##4 rsp.result == ~$past(req.dst, 4); endproperty
    property p_com_zs;
        tk |-> ##4 rsp.flags.z == (rsp.result == 8'h00) && rsp.flags.s == rsp.result[`CCA_SIGN_BIT];
    endproperty
    property p_com_keep;
        tk |-> ##4 !rsp.flags.v && {rsp.flags.c, rsp.flags.d, rsp.flags.h} == $past(cdh, 4);
    endproperty
    property p_com_ind; tk |-> ##4 rsp.dst_indirect == $past(req.opcode[0], 4); endproperty
    property p_cmp_lat; tc |-> s_cmp; endproperty
    property p_cmp_c; tc |-> ##6 rsp.flags.c == ($past(req.src, 6) > $past(req.dst, 6)); endproperty
    property p_cmp_z; tc |-> ##6 rsp.flags.z == ($past(req.src, 6) == $past(req.dst, 6)); endproperty
    property p_cmp_s;
        tc |-> ##6 rsp.result == 8'($past(req.dst, 6) - $past(req.src, 6)) && rsp.flags.s == rsp.result[7];
    endproperty
    property p_cmp_v;
        tc |-> ##6 {rsp.flags.d, rsp.flags.h} == $past(dh, 6) && rsp.flags.v ==
            ($past(req.dst[7], 6) != $past(req.src[7], 6) && rsp.result[7] != $past(req.dst[7], 6));
    endproperty
    property p_bad; bad |-> ##1 rsp.valid && rsp.refused && !rsp.write_en && req_ready; endproperty
    a_com_lat: assert property (p_com_lat) else $error("complement timing wrong");
    a_com_inv: assert property (p_com_inv) else $error("complement result wrong");
    a_com_zs: assert property (p_com_zs) else $error("complement z or s wrong");
    a_com_keep: assert property (p_com_keep) else $error("complement c d h v wrong");
    a_com_ind: assert property (p_com_ind) else $error("complement mode wrong");
    a_cmp_lat: assert property (p_cmp_lat) else $error("compare timing or write");
    a_cmp_c: assert property (p_cmp_c) else $error("compare carry wrong");
    a_cmp_z: assert property (p_cmp_z) else $error("compare zero wrong");
    a_cmp_s: assert property (p_cmp_s) else $error("compare sign wrong");
    a_cmp_v: assert property (p_cmp_v) else $error("compare v d h wrong");
    a_bad: assert property (p_bad) else $error("bad source mode taken");
endmodule

bind cca_alu cca_alu_checker u_chk (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp(rsp), .bus(bus), .bus_rdata(bus_rdata));

//--- test/tb.sv
// self-checking bench for cca_alu
// assumes the checker is bound from its own file
`timescale 1ns/10ps
`include "cca_defines.svh"
module tb;
    import cca_pkg::*;
    logic        core_clk, rst, req_valid, req_ready, rd_d, en;
    cca_req_t    req, r;
    cca_rsp_t    rsp, last;
    cca_bus_t    bus;
    logic [31:0] bus_rdata, lfsr;
    cca_rsp_t    rq[$];
    logic [31:0] bq[$];
    logic [15:0] pairs[7] = '{16'h0203, 16'h050a, 16'h8001, 16'h7fff, 16'h4444, 16'h0000, 16'hff00};
    int          errors, num_checks, cyc, n_done, n_ref;
    cca_alu dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req),
                 .req_ready(req_ready), .rsp(rsp), .bus(bus), .bus_rdata(bus_rdata));
    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic cca_rsp_t exp_of(input cca_req_t q, input logic e_on);
        cca_rsp_t   e;
        logic [7:0] d;
        e = '0;
        e.valid = 1'b1;
        e.flags = q.flags;
        e.result = q.dst;
        if (!e_on || (q.cmp ? q.src_mode > CCA_SRC_IMM : q.opcode[7:1] != 7'h30)) begin
            e.refused = 1'b1;
            return e;
        end
        d = q.cmp ? q.dst - q.src : ~q.dst;
        e.result = d;
        e.write_en = !q.cmp;
        e.dst_indirect = !q.cmp && q.opcode[0];
        e.flags.z = d == 8'h00;
        e.flags.s = d[7];
        e.flags.v = q.cmp && (q.dst[7] != q.src[7]) && (d[7] != q.dst[7]);
        if (q.cmp)
            e.flags.c = q.src > q.dst;
        return e;
    endfunction
    function automatic logic [31:0] st(input cca_rsp_t e);
        return {14'h0, 1'b0, e.refused, 2'b00, e.flags, e.result};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic op(input cca_req_t q);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= q;
        @(negedge core_clk);
        while (req_ready !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        req_valid <= 1'b0;
        last = exp_of(q, en);
        rq.push_back(last);
        if (last.refused)
            n_ref++;
        else
            n_done++;
    endtask
    task automatic idle;
        do @(negedge core_clk); while (req_ready !== 1'b1);
    endtask
    task automatic bw(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic br(input logic [3:0] a, input logic [31:0] x);
        @(posedge core_clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        bq.push_back(x);
        @(posedge core_clk);
        bus.rd <= 1'b0;
    endtask
    task automatic print_verdict;
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------
    // output monitor
    // ----------------
    always @(posedge core_clk) rd_d <= bus.rd;
    always @(negedge core_clk) begin
        cyc++;
        if (cyc > 6000) begin
            errors++;
            print_verdict();
        end
        if (rsp.valid === 1'b1)
            chk("rsp", 32'(rsp), rq.size() > 0 ? 32'(rq.pop_front()) : 32'hx);
        else
            chk("rsp_idle", 32'(rsp), 32'h0);
        if (rd_d === 1'b1)
            chk("bus_rdata", bus_rdata, bq.size() > 0 ? bq.pop_front() : 32'hx);
        else
            chk("rdata_idle", bus_rdata, 32'h0);
    end
    // ----------------
    // stimulus
    // ----------------
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        bus = '0;
        rd_d = 1'b0;
        en = 1'b1;
        lfsr = 32'h443d;
        errors = 0;
        num_checks = 0;
        cyc = 0;
        n_done = 0;
        n_ref = 0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk("ready", {31'h0, req_ready}, 32'h1);
        br(`CCA_OFS_CTRL, 32'h1);
        for (int i = 0; i < 14; i++) begin
            r = '{i[0], {7'h30, i[1]}, cca_src_mode_t'(i % 5), pairs[i / 2][15:8], pairs[i / 2][7:0], 6'h2a};
            op(r);
        end
        for (int i = 0; i < 80; i++) begin
            lfsr = nxt(lfsr);
            r = '{lfsr[0], lfsr[7:5] == 3'h0 ? lfsr[31:24] : {7'h30, lfsr[1]}, cca_src_mode_t'(lfsr[4:2]),
                  lfsr[15:8], lfsr[23:16], lfsr[29:24]};
            op(r);
            idle();
            br(`CCA_OFS_STATUS, st(last));
        end
        bw(`CCA_OFS_STATUS, 32'hffffffff);
        br(`CCA_OFS_STATUS, st(last));
        br(4'h2, 32'h0);
        br(`CCA_OFS_DONE_CNT, 32'(n_done));
        br(`CCA_OFS_REFUSE_CNT, 32'(n_ref));
        bw(`CCA_OFS_DONE_CNT, 32'h0);
        br(`CCA_OFS_DONE_CNT, 32'h0);
        br(`CCA_OFS_REFUSE_CNT, 32'(n_ref));
        bw(`CCA_OFS_REFUSE_CNT, 32'h0);
        br(`CCA_OFS_REFUSE_CNT, 32'h0);
        bw(`CCA_OFS_CTRL, 32'h0);
        en = 1'b0;
        br(`CCA_OFS_CTRL, 32'h0);
        op('{1'b0, 8'h60, CCA_SRC_WREG, 8'h5a, 8'h00, 6'h15});
        op('{1'b1, 8'h00, CCA_SRC_IMM, 8'h10, 8'h20, 6'h0a});
        idle();
        bw(`CCA_OFS_CTRL, 32'h1);
        en = 1'b1;
        op('{1'b0, 8'h61, CCA_SRC_WREG, 8'h07, 8'h00, 6'h3f});
        idle();
        repeat (3) @(negedge core_clk);
        chk("left", rq.size() + bq.size(), 32'h0);
        print_verdict();
    end
endmodule
